// *** hdl/irct_top.sv ***
// Internal reference clock trim registers and trimmed reference tick generators
`timescale 1ns/100ps
`default_nettype none
`include "irct_defs.svh"

module irct_top import irct_pkg::*; #(
    parameter int SLOW_CNT_W = 11,
    parameter int FAST_CNT_W = 5
) (
    input wire logic pclk, // Bus clock, 40 MHz
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic [7:0] factory_slow_trim, // Factory slow trim code
    input wire logic factory_slow_fine, // Factory slow fine trim bit
    input wire logic [3:0] factory_fast_trim, // Factory fast trim code
    output logic slow_ref_tick, // Slow reference tick
    output logic fast_ref_tick, // Fast reference tick
    output logic int_ref_tick, // Selected reference tick
    output logic [1:0] osc_range_field, // Controlled oscillator range
    output logic dco_max_32k_select, // Narrow range for 32.768 kHz reference
    output logic internal_ref_select // Active reference, 0 slow, 1 fast
);

    irct_apb_req_t req;
    irct_reg_sel_t sel;
    logic wr_en;
    logic rd_setup;

    irct_ctrl_t ctrl;
    irct_ctrl_t next_ctrl;
    irct_load_state_t ld_state;
    irct_load_state_t next_ld_state;

    logic [31:0] next_prdata;
    logic next_int_ref_tick;
    logic next_internal_ref_select;
    logic [1:0] next_osc_range_field;
    logic next_dco_max_32k_select;
    logic osc_run;

    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

    // Bus handshake and decode
    irct_apb_decode u_decode (
        .pclk(pclk),
        .presetn(presetn),
        .req(req),
        .sel(sel),
        .pready(pready),
        .pslverr(pslverr),
        .wr_en(wr_en),
        .rd_setup(rd_setup)
    );

    // Oscillators run once the factory trim has been taken
    assign osc_run = (ld_state == IRCT_LD_DONE);

    // Slow reference: nine-bit code, fine bit as least weight
    irct_ref_osc #(
        .CODE_W(9),
        .CNT_W(SLOW_CNT_W),
        .BASE_CYC(`IRCT_SLOW_BASE_CYC)
    ) u_slow_osc (
        .pclk(pclk),
        .presetn(presetn),
        .run(osc_run),
        .code({ctrl.slow_trim_code, ctrl.slow_fine_trim_bit}),
        .tick(slow_ref_tick)
    );

    // Fast reference trimmed by its own field
    irct_ref_osc #(
        .CODE_W(4),
        .CNT_W(FAST_CNT_W),
        .BASE_CYC(`IRCT_FAST_BASE_CYC)
    ) u_fast_osc (
        .pclk(pclk),
        .presetn(presetn),
        .run(osc_run),
        .code(ctrl.fast_trim_code),
        .tick(fast_ref_tick)
    );

    // Control state: factory load after reset release, then software writes
    always_comb begin
        next_ctrl = ctrl;
        next_ld_state = ld_state;
        unique case (ld_state)
            IRCT_LD_WAIT: begin
                next_ctrl.slow_trim_code = factory_slow_trim;
                next_ctrl.slow_fine_trim_bit = factory_slow_fine;
                next_ctrl.fast_trim_code = factory_fast_trim;
                next_ld_state = IRCT_LD_DONE;
            end
            IRCT_LD_DONE: begin
                if (wr_en && sel.slow_trim) begin
                    next_ctrl.slow_trim_code = pwdata[7:0];
                end
                if (wr_en && sel.range_trim) begin
                    next_ctrl.dco_max_32k_select = pwdata[`IRCT_C4_DCO_MAX_32K_SELECT_BIT];
                    next_ctrl.osc_range_field = pwdata[`IRCT_C4_RANGE_HI:`IRCT_C4_RANGE_LO];
                    next_ctrl.fast_trim_code = pwdata[`IRCT_C4_FAST_HI:`IRCT_C4_FAST_LO];
                    next_ctrl.slow_fine_trim_bit = pwdata[`IRCT_C4_FINE_BIT];
                end
                if (wr_en && sel.ref_select) begin
                    next_ctrl.internal_ref_select = pwdata[`IRCT_SEL_BIT];
                end
            end
            default: begin
                next_ld_state = IRCT_LD_WAIT;
            end
        endcase
    end

    // Control registers; trims reset to zero, then load from factory inputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ld_state <= IRCT_LD_WAIT;
            ctrl.slow_trim_code <= '0;
            ctrl.slow_fine_trim_bit <= 1'b0;
            ctrl.fast_trim_code <= '0;
            ctrl.osc_range_field <= `IRCT_RANGE_RESET;
            ctrl.dco_max_32k_select <= `IRCT_DCO_MAX_32K_SELECT_RESET;
            ctrl.internal_ref_select <= `IRCT_SEL_RESET;
        end else begin
            ld_state <= next_ld_state;
            ctrl <= next_ctrl;
        end
    end

    // Source switch happens on a tick of the newly requested source, so no runt tick leaks out
    always_comb begin
        next_internal_ref_select = internal_ref_select;
        if (ctrl.internal_ref_select && fast_ref_tick) begin
            next_internal_ref_select = 1'b1;
        end else if (!ctrl.internal_ref_select && slow_ref_tick) begin
            next_internal_ref_select = 1'b0;
        end
        next_int_ref_tick = internal_ref_select ? fast_ref_tick : slow_ref_tick;
        next_osc_range_field = ctrl.osc_range_field;
        next_dco_max_32k_select = ctrl.dco_max_32k_select;
    end

    // Read data prepared in the setup cycle, held through the access cycle
    always_comb begin
        next_prdata = prdata;
        if (rd_setup) begin
            next_prdata = 32'h0000_0000;
            if (sel_now_slow(paddr)) begin
                next_prdata[7:0] = ctrl.slow_trim_code;
            end else if (sel_now_idx(paddr, `IRCT_IDX_RANGE_TRIM)) begin
                next_prdata[`IRCT_C4_DCO_MAX_32K_SELECT_BIT] = ctrl.dco_max_32k_select;
                next_prdata[`IRCT_C4_RANGE_HI:`IRCT_C4_RANGE_LO] = ctrl.osc_range_field;
                next_prdata[`IRCT_C4_FAST_HI:`IRCT_C4_FAST_LO] = ctrl.fast_trim_code;
                next_prdata[`IRCT_C4_FINE_BIT] = ctrl.slow_fine_trim_bit;
            end else if (sel_now_idx(paddr, `IRCT_IDX_REF_SELECT)) begin
                next_prdata[`IRCT_SEL_BIT] = ctrl.internal_ref_select;
            end else if (sel_now_idx(paddr, `IRCT_IDX_STATUS)) begin
                next_prdata[`IRCT_STAT_ACTIVE_BIT] = internal_ref_select;
                next_prdata[`IRCT_STAT_LOADED_BIT] = osc_run;
                next_prdata[`IRCT_STAT_REQ_BIT] = ctrl.internal_ref_select;
            end
        end
    end

    // Aligned word match against a register index
    function automatic logic sel_now_idx(input logic [11:0] addr, input logic [9:0] idx);
        return (addr[1:0] == 2'h0) && (addr[11:2] == idx);
    endfunction

    // Slow trim register match
    function automatic logic sel_now_slow(input logic [11:0] addr);
        return sel_now_idx(addr, `IRCT_IDX_SLOW_TRIM);
    endfunction

    // Output registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            int_ref_tick <= 1'b0;
            internal_ref_select <= `IRCT_SEL_RESET;
            osc_range_field <= `IRCT_RANGE_RESET;
            dco_max_32k_select <= `IRCT_DCO_MAX_32K_SELECT_RESET;
        end else begin
            prdata <= next_prdata;
            int_ref_tick <= next_int_ref_tick;
            internal_ref_select <= next_internal_ref_select;
            osc_range_field <= next_osc_range_field;
            dco_max_32k_select <= next_dco_max_32k_select;
        end
    end

endmodule

`default_nettype wire

// *** hdl/irct_defs.svh ***
// Register indices, field positions, reset values and timing constants for the reference trim block
`ifndef IRCT_DEFS_SVH
`define IRCT_DEFS_SVH

// Register indices; byte address is four times the index
`define IRCT_IDX_REF_SELECT 10'h001
`define IRCT_IDX_SLOW_TRIM 10'h002
`define IRCT_IDX_RANGE_TRIM 10'h003
`define IRCT_IDX_STATUS 10'h004

// Fields of oscillator_range_and_fine_trim
`define IRCT_C4_DCO_MAX_32K_SELECT_BIT 7
`define IRCT_C4_RANGE_HI 6
`define IRCT_C4_RANGE_LO 5
`define IRCT_C4_FAST_HI 4
`define IRCT_C4_FAST_LO 1
`define IRCT_C4_FINE_BIT 0

// Fields of ref_select and status
`define IRCT_SEL_BIT 0
`define IRCT_STAT_ACTIVE_BIT 0
`define IRCT_STAT_LOADED_BIT 1
`define IRCT_STAT_REQ_BIT 2

// Reset values of bus-writable controls
`define IRCT_RANGE_RESET 2'h0
`define IRCT_DCO_MAX_32K_SELECT_RESET 1'h0
`define IRCT_SEL_RESET 1'h0

// Nominal reference periods in ns and their base cycle counts at the bus clock rate
`define IRCT_CLK_PERIOD_NS 25
`define IRCT_SLOW_BASE_NS 25000
`define IRCT_FAST_BASE_NS 250
`define IRCT_SLOW_BASE_CYC (`IRCT_SLOW_BASE_NS / `IRCT_CLK_PERIOD_NS)
`define IRCT_FAST_BASE_CYC (`IRCT_FAST_BASE_NS / `IRCT_CLK_PERIOD_NS)

`endif

// *** hdl/irct_pkg.sv ***
// Types shared by the reference trim block
package irct_pkg;

    // APB request as seen by the slave
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } irct_apb_req_t;

    // One-hot register decode
    typedef struct packed {
        logic ref_select;
        logic slow_trim;
        logic range_trim;
        logic status;
    } irct_reg_sel_t;

    // Control state held for the oscillators
    typedef struct packed {
        logic [7:0] slow_trim_code;
        logic slow_fine_trim_bit;
        logic [3:0] fast_trim_code;
        logic [1:0] osc_range_field;
        logic dco_max_32k_select;
        logic internal_ref_select;
    } irct_ctrl_t;

    // Factory load sequencing
    typedef enum logic [1:0] {
        IRCT_LD_WAIT = 2'b00,
        IRCT_LD_DONE = 2'b01
    } irct_load_state_t;

endpackage

// *** hdl/irct_ref_osc.sv ***
// Trimmed period generator: emits a one-cycle tick every base-plus-code cycles
`timescale 1ns/100ps
`default_nettype none

module irct_ref_osc import irct_pkg::*; #(
    parameter int CODE_W = 9,
    parameter int CNT_W = 12,
    parameter int BASE_CYC = 1000
) (
    input wire logic pclk, // Bus clock
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic run, // Oscillator running
    input wire logic [CODE_W-1:0] code, // Binary weighted trim code
    output logic tick // One-cycle pulse per period
);

    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic next_tick;
    logic [CNT_W-1:0] last;

    // Larger code gives a longer period, each code bit doubling its weight
    always_comb begin
        last = CNT_W'(BASE_CYC - 1) + CNT_W'(code);
        next_cnt = cnt;
        next_tick = 1'b0;
        if (!run) begin
            next_cnt = '0;
        end else if (cnt >= last) begin
            next_cnt = '0;
            next_tick = 1'b1;
        end else begin
            next_cnt = cnt + CNT_W'(1);
        end
    end

    // Counter registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
            tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick <= next_tick;
        end
    end

endmodule

`default_nettype wire

// *** hdl/irct_apb_decode.sv ***
// APB slave handshake: address decode, no wait states, error on unmapped addresses
`timescale 1ns/100ps
`default_nettype none
`include "irct_defs.svh"

module irct_apb_decode import irct_pkg::*; (
    input wire logic pclk, // Bus clock
    input wire logic presetn, // Asynchronous reset, active low
    input wire irct_apb_req_t req, // APB request
    output irct_reg_sel_t sel, // Decoded register, held through access
    output logic pready, // Ready, high in the access cycle
    output logic pslverr, // Error for unmapped address
    output logic wr_en, // Write takes effect this edge
    output logic rd_setup // Setup cycle of a read
);

    irct_reg_sel_t next_sel;
    logic next_pready;
    logic next_pslverr;
    logic setup;

    // Word index decode, aligned words only
    function automatic irct_reg_sel_t decode(input logic [11:0] addr);
        irct_reg_sel_t s;
        s = '0;
        if (addr[1:0] == 2'h0) begin
            s.ref_select = (addr[11:2] == `IRCT_IDX_REF_SELECT);
            s.slow_trim = (addr[11:2] == `IRCT_IDX_SLOW_TRIM);
            s.range_trim = (addr[11:2] == `IRCT_IDX_RANGE_TRIM);
            s.status = (addr[11:2] == `IRCT_IDX_STATUS);
        end
        return s;
    endfunction

    // Ready and error are prepared in the setup cycle
    always_comb begin
        setup = req.psel && !req.penable;
        next_sel = setup ? decode(req.paddr) : sel;
        next_pready = setup;
        next_pslverr = setup && (decode(req.paddr) == '0);
        wr_en = req.psel && req.penable && pready && req.pwrite && !pslverr;
        rd_setup = setup && !req.pwrite;
    end

    // Handshake registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            sel <= next_sel;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

endmodule

`default_nettype wire

// *** dv/irct_top_assertions.sv ***
// Port-level property checker for the reference trim block
`timescale 1ns/100ps
`default_nettype none
module irct_chk (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pwrite, // Direction
    input wire logic [11:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic slow_ref_tick, // Slow tick
    input wire logic fast_ref_tick, // Fast tick
    input wire logic int_ref_tick, // Selected tick
    input wire logic [1:0] osc_range_field, // Range
    input wire logic dco_max_32k_select, // Narrow range
    input wire logic internal_ref_select // Active source
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [11:0] gap, next_gap;
    logic seen, next_seen;
    // Cycles since the last slow tick
    always_comb begin
        next_gap = slow_ref_tick ? 12'h000 : gap + 12'h001;
        next_seen = seen | slow_ref_tick;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap <= 12'h000;
            seen <= 1'b0;
        end else begin
            gap <= next_gap;
            seen <= next_seen;
        end
    end
    a_ready_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
    a_ready_access: assert property (pready |-> psel && penable) else $error("ready outside access");
    a_err_unmapped: assert property (psel && penable && (paddr[1:0] != 2'h0 || paddr > 12'h010 ||
        paddr < 12'h004) |-> pslverr) else $error("unmapped access not refused");
    a_range_reset: assert property ($rose(presetn) |-> ##1 osc_range_field == 2'h0 && !dco_max_32k_select)
        else $error("range not cleared by reset");
    a_range_write: assert property (psel && penable && pready && pwrite && paddr == 12'h00C |-> ##2
        {dco_max_32k_select, osc_range_field} == $past(pwdata[7:5], 2)) else $error("range not updated");
    a_slow_gap: assert property (slow_ref_tick && seen |-> gap >= 12'h3E7) else $error("slow period short");
    a_fast_gap: assert property (fast_ref_tick |=> !fast_ref_tick [*8]) else $error("fast period short");
    a_switch_tick: assert property ($changed(internal_ref_select) |-> (internal_ref_select ?
        fast_ref_tick || $past(fast_ref_tick) : slow_ref_tick || $past(slow_ref_tick)))
        else $error("source switch off tick");
    a_int_source: assert property (int_ref_tick && $stable(internal_ref_select) |->
        (internal_ref_select ? $past(fast_ref_tick) : $past(slow_ref_tick))) else $error("wrong selected tick");
endmodule
bind irct_top irct_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .slow_ref_tick(slow_ref_tick), .fast_ref_tick(fast_ref_tick), .int_ref_tick(int_ref_tick),
    .osc_range_field(osc_range_field), .dco_max_32k_select(dco_max_32k_select),
    .internal_ref_select(internal_ref_select));
`default_nettype wire

// *** dv/irct_top_tb.sv ***
// Self-checking bench for the reference trim block
`timescale 1ns/100ps
`default_nettype none
module irct_top_tb;
    typedef struct packed {
        logic w;
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] q;
        logic e;
    } irct_row_t;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, t_slow, t_fast, t_int, dco, ref_sel;
    logic [1:0] range;
    logic [7:0] f_slow = 8'h3C;
    logic f_fine = 1'b1;
    logic [3:0] f_fast = 4'h9, fb = 4'hC;
    logic [7:0] sc [4] = '{8'h00, 8'h01, 8'h00, 8'hFF};
    int errors = 0, checks = 0, n;
    irct_row_t rows [12] = '{
        '{1'b1, 12'h008, 32'hFFFFFF5A, 32'h0, 1'b0}, '{1'b0, 12'h008, 32'h0, 32'h5A, 1'b0},
        '{1'b1, 12'h00C, 32'hFF, 32'h0, 1'b0}, '{1'b0, 12'h00C, 32'h0, 32'hFF, 1'b0},
        '{1'b1, 12'h004, 32'h1, 32'h0, 1'b0}, '{1'b0, 12'h004, 32'h0, 32'h1, 1'b0},
        '{1'b1, 12'h004, 32'h0, 32'h0, 1'b0}, '{1'b0, 12'h014, 32'h0, 32'h0, 1'b1},
        '{1'b1, 12'h002, 32'h5, 32'h0, 1'b1}, '{1'b0, 12'h000, 32'h0, 32'h0, 1'b1},
        '{1'b1, 12'h00C, 32'h0, 32'h0, 1'b0}, '{1'b0, 12'h00C, 32'h0, 32'h0, 1'b0}};
    irct_top i_irct_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .factory_slow_trim(f_slow), .factory_slow_fine(f_fine), .factory_fast_trim(f_fast),
        .slow_ref_tick(t_slow), .fast_ref_tick(t_fast), .int_ref_tick(t_int), .osc_range_field(range),
        .dco_max_32k_select(dco), .internal_ref_select(ref_sel));
    // Clock, 25 ns period
    always #12.5 pclk = ~pclk;
    task results;
        if (errors == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One APB transfer, held until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        // Values read just after the edge are the ones that edge sampled
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Cycles between two ticks of source s: 0 slow, 1 fast, 2 selected
    task period(input int s, output int p);
        repeat (2) begin
            p = 0;
            do begin
                @(negedge pclk);
                p++;
            end while ((s == 0 ? t_slow : s == 1 ? t_fast : t_int) !== 1'b1 && p < 3000);
        end
    endtask
    // Factory loads and cleared controls after reset
    task reset_check;
        apb(1'b0, 12'h008, 32'h0);
        chk("slow_trim", rd, {24'h0, f_slow});
        apb(1'b0, 12'h00C, 32'h0);
        chk("range_trim", rd, {27'h0, f_fast, f_fine});
        chk("outputs", {dco, range, ref_sel}, 32'h0);
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        reset_check;
        // Register table
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk("pslverr", err, rows[i].e);
            if (!rows[i].w) chk("prdata", rd, rows[i].q);
        end
        // Trim codes against measured periods
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 12'h008, {24'h0, sc[i]});
            apb(1'b1, 12'h00C, {27'h0, 4'(i * 5), fb[i]});
            period(0, n);
            chk("slow_period", n, 1000 + 2 * sc[i] + fb[i]);
            period(1, n);
            chk("fast_period", n, 10 + i * 5);
        end
        // Source select both ways
        apb(1'b1, 12'h004, 32'h1);
        period(1, n);
        period(2, n);
        chk("fast_selected", n, 25);
        apb(1'b0, 12'h010, 32'h0);
        chk("status", rd, 32'h7);
        apb(1'b1, 12'h004, 32'h0);
        period(0, n);
        period(2, n);
        chk("slow_selected", n, 1511);
        chk("select", ref_sel, 32'h0);
        // Narrow range and range field
        apb(1'b1, 12'h00C, 32'hC0);
        repeat (2) @(negedge pclk);
        chk("dco_range", {dco, range}, 32'h6);
        // Second reset with other factory values
        @(posedge pclk);
        presetn <= 1'b0;
        f_slow <= 8'hC3;
        f_fine <= 1'b0;
        f_fast <= 4'h6;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        reset_check;
        results;
    end
    // Cuts a hang short
    initial begin
        repeat (60000) @(posedge pclk);
        errors++;
        results;
    end
endmodule
`default_nettype wire
